// ---- core/msf_pkg.sv ----
package msf_pkg;
    // Register port geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    // Register offsets
    localparam logic [ADDR_W-1:0] AUTOCAL_RUN_FLAGS_ADDR = 12'h4C0;
    localparam logic [ADDR_W-1:0] POWER_QUALITY_EVENT_FLAGS_ADDR = 12'h4C1;
    localparam logic [ADDR_W-1:0] DEVICE_ERROR_FLAGS_ADDR = 12'h4C2;
    // Reset value of every flag register
    localparam logic [DATA_W-1:0] FLAGS_RESET = 16'h0000;
    // Autocalibration flag positions
    localparam int CALIB_TIMEOUT_BIT = 3;
    localparam int CALIB_READY_BIT = 1;
    localparam int CALIB_SHIFT_BIT = 0;
    // Event flag positions
    localparam int OC_B_BIT = 5;
    localparam int OC_A_BIT = 4;
    localparam int SWELL_BIT = 2;
    localparam int DIP_BIT = 0;
    // Device error flag positions
    localparam int SERIAL_RESET_BIT = 7;
    localparam int SERIAL_FAULT_LSB = 4;
    localparam int SERIAL_FAULT_N = 3;
    localparam int INTERNAL_FAULT_LSB = 0;
    localparam int INTERNAL_FAULT_N = 4;
    // Calibration timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int NS_PER_SEC = 1000000000;
    localparam int SEC_CYCLES = NS_PER_SEC / CLK_PERIOD_NS;
    localparam int CALIB_TIMEOUT_S = 600;
    localparam int CALIB_FIRST_S = 8;
    localparam int CALIB_REFRESH_S = 1;
    localparam int SEC_CNT_W = 10;
    localparam int COEFF_W = 24;
endpackage : msf_pkg

// ---- core/msf_status_flags.sv ----
module msf_status_flags
    import msf_pkg::*;
#(
    parameter int SEC_CYCLES_P = msf_pkg::SEC_CYCLES,
    parameter int COEFF_WIDTH = msf_pkg::COEFF_W
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register read port
    input wire logic reg_rd_en,
    input wire logic [msf_pkg::ADDR_W-1:0] reg_addr,
    output logic reg_rvalid_ff,
    output logic [msf_pkg::DATA_W-1:0] reg_rdata_ff,
    // Autocalibration engine
    input wire logic calib_run,
    input wire logic calib_coeff_valid,
    input wire logic [COEFF_WIDTH-1:0] calib_coefficient,
    // Power quality detectors
    input wire logic overcurrent_chan_a,
    input wire logic overcurrent_chan_b,
    input wire logic voltage_swell,
    input wire logic voltage_dip,
    // Serial port and fault sources
    input wire logic serial_reset_det,
    input wire logic [msf_pkg::SERIAL_FAULT_N-1:0] serial_fault_set,
    input wire logic [msf_pkg::INTERNAL_FAULT_N-1:0] internal_fault_set,
    input wire logic soft_reset,
    // Flag outputs
    output logic [msf_pkg::DATA_W-1:0] autocal_run_flags_ff,
    output logic [msf_pkg::DATA_W-1:0] power_quality_event_flags_ff,
    output logic [msf_pkg::DATA_W-1:0] device_error_flags_ff
);
    import msf_pkg::*;

    localparam logic [SEC_CNT_W-1:0] FIRST_SEC = SEC_CNT_W'(CALIB_FIRST_S);
    localparam logic [SEC_CNT_W-1:0] TIMEOUT_SEC = SEC_CNT_W'(CALIB_TIMEOUT_S);
    localparam logic [SEC_CNT_W-1:0] REFRESH_SEC = SEC_CNT_W'(CALIB_REFRESH_S);
    localparam logic [63:0] SEC_LAST = 64'(SEC_CYCLES_P - 1);

    typedef enum logic [1:0] {MSF_IDLE, MSF_RUN, MSF_EXPIRED} msf_run_e;

    // Address decode used by the read mux
    function automatic logic [1:0] msf_decode(input logic [ADDR_W-1:0] addr);
        case (addr)
            AUTOCAL_RUN_FLAGS_ADDR: msf_decode = 2'h1;
            POWER_QUALITY_EVENT_FLAGS_ADDR: msf_decode = 2'h2;
            DEVICE_ERROR_FLAGS_ADDR: msf_decode = 2'h3;
            default: msf_decode = 2'h0;
        endcase
    endfunction : msf_decode

    msf_run_e state_ff;
    msf_run_e nxt_state;
    logic [63:0] presc_ff;
    logic [63:0] nxt_presc;
    logic [SEC_CNT_W-1:0] sec_ff;
    logic [SEC_CNT_W-1:0] nxt_sec;
    logic [COEFF_WIDTH-1:0] coeff_ff;
    logic [COEFF_WIDTH-1:0] nxt_coeff;
    logic coeff_seen_ff;
    logic nxt_coeff_seen;
    logic ready_evt_ff;
    logic nxt_ready_evt;
    logic sec_tick;
    logic [DATA_W-1:0] nxt_autocal;
    logic [DATA_W-1:0] nxt_event;
    logic [DATA_W-1:0] nxt_error;
    logic nxt_rvalid;
    logic [DATA_W-1:0] nxt_rdata;

    assign sec_tick = (state_ff == MSF_RUN) && calib_run && (presc_ff == SEC_LAST);

    // Run sequencer; the long count is a parameter so simulation can shrink a second
    always_comb
    begin
        nxt_state = state_ff;
        nxt_presc = presc_ff;
        nxt_sec = sec_ff;
        nxt_ready_evt = 1'b0;
        case (state_ff)
            MSF_IDLE:
            begin
                nxt_presc = '0;
                nxt_sec = '0;
                if (calib_run)
                begin
                    nxt_state = MSF_RUN;
                end
            end
            MSF_RUN:
            begin
                if (!calib_run)
                begin
                    nxt_state = MSF_IDLE;
                end
                else if (sec_tick)
                begin
                    nxt_presc = '0;
                    nxt_sec = sec_ff + REFRESH_SEC;
                    if (sec_ff + REFRESH_SEC >= FIRST_SEC)
                    begin
                        nxt_ready_evt = 1'b1;
                    end
                    if (sec_ff + REFRESH_SEC == TIMEOUT_SEC)
                    begin
                        nxt_state = MSF_EXPIRED;
                    end
                end
                else
                begin
                    nxt_presc = presc_ff + 64'h1;
                end
            end
            MSF_EXPIRED:
            begin
                // Stays stopped until the engine drops its run request
                if (!calib_run)
                begin
                    nxt_state = MSF_IDLE;
                end
            end
            default: nxt_state = MSF_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_ff <= MSF_IDLE;
            presc_ff <= '0;
            sec_ff <= '0;
            ready_evt_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            presc_ff <= nxt_presc;
            sec_ff <= nxt_sec;
            ready_evt_ff <= nxt_ready_evt;
        end
    end

    // Autocalibration flags; sticky for the run, wiped when a fresh run starts
    always_comb
    begin
        nxt_autocal = autocal_run_flags_ff;
        nxt_coeff = coeff_ff;
        nxt_coeff_seen = coeff_seen_ff;
        if (state_ff == MSF_IDLE && calib_run)
        begin
            nxt_autocal = FLAGS_RESET;
            nxt_coeff_seen = 1'b0;
        end
        if (ready_evt_ff)
        begin
            nxt_autocal[CALIB_READY_BIT] = 1'b1;
        end
        if (state_ff == MSF_RUN && nxt_state == MSF_EXPIRED)
        begin
            nxt_autocal[CALIB_TIMEOUT_BIT] = 1'b1;
        end
        if (state_ff == MSF_RUN && calib_run && calib_coeff_valid)
        begin
            nxt_coeff = calib_coefficient;
            nxt_coeff_seen = 1'b1;
            if (coeff_seen_ff && calib_coefficient != coeff_ff)
            begin
                nxt_autocal[CALIB_SHIFT_BIT] = 1'b1;
            end
        end
    end

    // Event flags are live copies of the detectors, not sticky
    always_comb
    begin
        nxt_event = FLAGS_RESET;
        nxt_event[OC_B_BIT] = overcurrent_chan_b;
        nxt_event[OC_A_BIT] = overcurrent_chan_a;
        nxt_event[SWELL_BIT] = voltage_swell;
        nxt_event[DIP_BIT] = voltage_dip;
    end

    // Error flags; a new fault in the clearing cycle is kept, set wins
    always_comb
    begin
        nxt_error = device_error_flags_ff;
        if (soft_reset)
        begin
            nxt_error = FLAGS_RESET;
        end
        if (serial_reset_det)
        begin
            nxt_error[SERIAL_FAULT_LSB +: SERIAL_FAULT_N] = '0;
        end
        nxt_error[SERIAL_FAULT_LSB +: SERIAL_FAULT_N] =
            nxt_error[SERIAL_FAULT_LSB +: SERIAL_FAULT_N] | serial_fault_set;
        nxt_error[INTERNAL_FAULT_LSB +: INTERNAL_FAULT_N] =
            nxt_error[INTERNAL_FAULT_LSB +: INTERNAL_FAULT_N] | internal_fault_set;
        if (serial_reset_det)
        begin
            nxt_error[SERIAL_RESET_BIT] = 1'b1;
        end
    end

    // Read mux; there is no write path, so writes cannot disturb flags
    always_comb
    begin
        nxt_rvalid = reg_rd_en;
        case (msf_decode(reg_addr))
            2'h1: nxt_rdata = autocal_run_flags_ff;
            2'h2: nxt_rdata = power_quality_event_flags_ff;
            2'h3: nxt_rdata = device_error_flags_ff;
            default: nxt_rdata = FLAGS_RESET;
        endcase
        if (!reg_rd_en)
        begin
            nxt_rdata = reg_rdata_ff;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            autocal_run_flags_ff <= FLAGS_RESET;
            power_quality_event_flags_ff <= FLAGS_RESET;
            device_error_flags_ff <= FLAGS_RESET;
            coeff_ff <= '0;
            coeff_seen_ff <= 1'b0;
            reg_rvalid_ff <= 1'b0;
            reg_rdata_ff <= FLAGS_RESET;
        end
        else
        begin
            autocal_run_flags_ff <= nxt_autocal;
            power_quality_event_flags_ff <= nxt_event;
            device_error_flags_ff <= nxt_error;
            coeff_ff <= nxt_coeff;
            coeff_seen_ff <= nxt_coeff_seen;
            reg_rvalid_ff <= nxt_rvalid;
            reg_rdata_ff <= nxt_rdata;
        end
    end

    default clocking msf_cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    timeout_set_a: assert property (
        (!srst && state_ff == MSF_RUN && sec_tick && sec_ff == TIMEOUT_SEC - 10'h1)
        |=> autocal_run_flags_ff[CALIB_TIMEOUT_BIT] && state_ff == MSF_EXPIRED)
        else $error("timeout flag not set at run limit");

    ready_first_a: assert property (
        (!srst && sec_tick && sec_ff == FIRST_SEC - 10'h1)
        |=> ##1 autocal_run_flags_ff[CALIB_READY_BIT])
        else $error("ready flag missing after first block");

    ready_early_a: assert property (
        (state_ff == MSF_RUN && sec_ff < FIRST_SEC - 10'h1) |=> !ready_evt_ff)
        else $error("ready event before first block");

    ready_refresh_a: assert property (
        (!srst && sec_tick && sec_ff >= FIRST_SEC)
        |=> ready_evt_ff ##1 autocal_run_flags_ff[CALIB_READY_BIT])
        else $error("ready refresh missing");

    coeff_shift_a: assert property (
        (!srst && state_ff == MSF_RUN && calib_run && calib_coeff_valid && coeff_seen_ff
         && calib_coefficient != coeff_ff) |=> autocal_run_flags_ff[CALIB_SHIFT_BIT])
        else $error("coefficient shift not flagged");

    overcurrent_a: assert property (
        !srst |=> power_quality_event_flags_ff[OC_A_BIT] == $past(overcurrent_chan_a)
        && power_quality_event_flags_ff[OC_B_BIT] == $past(overcurrent_chan_b))
        else $error("overcurrent flag does not follow channel");

    swell_level_a: assert property (
        !srst |=> power_quality_event_flags_ff[SWELL_BIT] == $past(voltage_swell))
        else $error("swell flag does not follow level");

    dip_level_a: assert property (
        !srst |=> power_quality_event_flags_ff[DIP_BIT] == $past(voltage_dip))
        else $error("dip flag does not follow level");

    serial_reset_a: assert property (
        serial_reset_det && !srst |=> device_error_flags_ff[SERIAL_RESET_BIT])
        else $error("serial reset not indicated");

    serial_hold_a: assert property (
        (!srst && !serial_reset_det && !soft_reset)
        |=> (device_error_flags_ff[6:4] & $past(device_error_flags_ff[6:4]))
        == $past(device_error_flags_ff[6:4]))
        else $error("serial fault cleared without serial reset");

    internal_hold_a: assert property (
        !soft_reset && !srst |=> (device_error_flags_ff[3:0] & $past(device_error_flags_ff[3:0]))
        == $past(device_error_flags_ff[3:0]))
        else $error("internal fault cleared without reset");

    reset_zero_a: assert property (
        $past(srst) |-> device_error_flags_ff == FLAGS_RESET
        && autocal_run_flags_ff == FLAGS_RESET && !reg_rvalid_ff)
        else $error("flags not zero after reset");

endmodule : msf_status_flags

// ---- verification/msf_host_model.sv ----
module msf_host_model
    import msf_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Read request
    output logic reg_rd_en,
    output logic [msf_pkg::ADDR_W-1:0] reg_addr,
    // Read answer
    input wire logic reg_rvalid_ff,
    input wire logic [msf_pkg::DATA_W-1:0] reg_rdata_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        reg_rd_en = 1'b0;
        reg_addr = 12'h000;
    end

    // reads only, no write path
    // One-cycle pulse; released address is scrambled so stale values never match
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                            output logic ok);
        int i;
        ok = 1'b0;
        d = 16'h0000;
        @(posedge mclk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        for (i = 0; i < 4 && ok == 1'b0; i++)
        begin
            #1;
            if (reg_rvalid_ff === 1'b1)
            begin
                ok = 1'b1;
                d = reg_rdata_ff;
            end
            else
                @(posedge mclk);
        end
    endtask : read_reg
endmodule : msf_host_model

// ---- verification/tb.sv ----
module tb;
    import msf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Short second keeps the 600 s timeout at about 6000 cycles
    localparam int SECP = 10;
    logic mclk, srst, rd_en, rvalid, run, cvalid, oc_a, oc_b, swell, dip, ser_rst, soft_rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rdata, f_cal, f_pq, f_err;
    logic [23:0] coeff;
    logic [2:0] ser_set;
    logic [3:0] int_set;
    int n_fail = 0;
    int compares = 0;

    msf_status_flags #(.SEC_CYCLES_P(SECP), .COEFF_WIDTH(24)) dut_u (
        .mclk(mclk), .srst(srst), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_rvalid_ff(rvalid), .reg_rdata_ff(rdata), .calib_run(run),
        .calib_coeff_valid(cvalid), .calib_coefficient(coeff),
        .overcurrent_chan_a(oc_a), .overcurrent_chan_b(oc_b), .voltage_swell(swell),
        .voltage_dip(dip), .serial_reset_det(ser_rst), .serial_fault_set(ser_set),
        .internal_fault_set(int_set), .soft_reset(soft_rst), .autocal_run_flags_ff(f_cal),
        .power_quality_event_flags_ff(f_pq), .device_error_flags_ff(f_err));

    msf_host_model host_u (.mclk(mclk), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_rvalid_ff(rvalid), .reg_rdata_ff(rdata));

    // 200 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Read through the host model; a missing answer ends the run
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                          input string what);
        logic [DATA_W-1:0] d;
        logic ok;
        host_u.read_reg(a, d, ok);
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected answer seen none", what);
            report_and_stop();
        end
        chk(what, d, exp);
    endtask : rd_chk

    // Bounded wait for one autocal flag
    task automatic wait_cal(input int b, input int maxc);
        int i;
        for (i = 0; i < maxc; i++)
        begin
            @(posedge mclk);
            #1;
            if (f_cal[b] === 1'b1)
                return;
        end
        n_fail++;
        $display("CHECK FAILED autocal bit %0d expected 1 seen 0", b);
        report_and_stop();
    endtask : wait_cal

    // Main sequence
    initial
    begin
        {srst, run, cvalid, oc_a, oc_b, swell, dip, ser_rst, soft_rst} = 9'h1FF;
        {run, cvalid, oc_a, oc_b, swell, dip, ser_rst, soft_rst} = 8'h00;
        coeff = 24'h000000;
        ser_set = 3'h0;
        int_set = 4'h0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        for (int k = 0; k < 4; k++)
            rd_chk(AUTOCAL_RUN_FLAGS_ADDR + 12'(k), FLAGS_RESET, "reset value");
        // Every detector combination, each held until the next one is driven
        for (int i = 0; i < 16; i++)
        begin
            @(posedge mclk);
            {oc_b, oc_a, swell, dip} <= 4'(i);
            @(posedge mclk);
            rd_chk(POWER_QUALITY_EVENT_FLAGS_ADDR, {10'h000, 2'(i >> 2), 1'b0, 1'(i >> 1),
                   1'b0, 1'(i)}, "event flags");
        end
        @(posedge mclk);
        {oc_b, oc_a, swell, dip} <= 4'h0;
        ser_set <= 3'h5;
        int_set <= 4'hA;
        @(posedge mclk);
        ser_set <= 3'h0;
        int_set <= 4'h0;
        rd_chk(DEVICE_ERROR_FLAGS_ADDR, 16'h005A, "faults held");
        chk("error flags out", f_err, 16'h005A);
        chk("dip cleared", f_pq, FLAGS_RESET);
        // host resets the serial port; a fault in the same cycle is kept
        @(posedge mclk);
        ser_rst <= 1'b1;
        ser_set <= 3'h2;
        @(posedge mclk);
        ser_rst <= 1'b0;
        ser_set <= 3'h0;
        rd_chk(DEVICE_ERROR_FLAGS_ADDR, 16'h00AA, "serial reset");
        @(posedge mclk);
        soft_rst <= 1'b1;
        @(posedge mclk);
        soft_rst <= 1'b0;
        rd_chk(DEVICE_ERROR_FLAGS_ADDR, FLAGS_RESET, "soft reset");
        @(posedge mclk);
        int_set <= 4'h5;
        @(posedge mclk);
        int_set <= 4'h0;
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        rd_chk(DEVICE_ERROR_FLAGS_ADDR, FLAGS_RESET, "hard reset");
        // Autocal run: equal estimates give no shift
        @(posedge mclk);
        run <= 1'b1;
        coeff <= 24'h123456;
        repeat (2)
        begin
            @(posedge mclk);
            cvalid <= 1'b1;
            @(posedge mclk);
            cvalid <= 1'b0;
        end
        repeat (30) @(posedge mclk);
        rd_chk(AUTOCAL_RUN_FLAGS_ADDR, FLAGS_RESET, "before first block");
        @(posedge mclk);
        coeff <= 24'h123457;
        cvalid <= 1'b1;
        @(posedge mclk);
        cvalid <= 1'b0;
        rd_chk(AUTOCAL_RUN_FLAGS_ADDR, 16'h0001, "shift");
        wait_cal(CALIB_READY_BIT, 60);
        repeat (5600) @(posedge mclk);
        rd_chk(AUTOCAL_RUN_FLAGS_ADDR, 16'h0003, "before timeout");
        wait_cal(CALIB_TIMEOUT_BIT, 400);
        // host stops and repeats the run with the same settings
        @(posedge mclk);
        run <= 1'b0;
        rd_chk(AUTOCAL_RUN_FLAGS_ADDR, 16'h000B, "after stop");
        @(posedge mclk);
        run <= 1'b1;
        cvalid <= 1'b1;
        @(posedge mclk);
        cvalid <= 1'b0;
        rd_chk(AUTOCAL_RUN_FLAGS_ADDR, FLAGS_RESET, "rerun");
        report_and_stop();
    end
endmodule : tb
